// ===== core/i2csr_pkg.sv
// constants and types shared by the two-wire slave port and its bus master

package i2csr_pkg;

	// ****************************************
	// widths and address patterns
	// ****************************************
	localparam int BYTE_W = 8;
	localparam int CNT_W = 4;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] ACK_SLOT = 4'h9;
	localparam logic [4:0] TEN_HDR = 5'h1e;

	// ****************************************
	// slave flag layout
	// ****************************************
	localparam int INT_W = 2;
	localparam int INT_PIF = 0;
	localparam int INT_OV = 1;

	// ****************************************
	// master register map (byte addresses)
	// ****************************************
	localparam int AW = 8;
	localparam int DW = 32;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_TXD = 8'h04;
	localparam logic [7:0] OFF_RXD = 8'h08;
	localparam logic [7:0] OFF_STAT = 8'h0c;
	localparam logic [7:0] OFF_ISTAT = 8'h10;
	localparam logic [7:0] OFF_IMASK = 8'h14;
	localparam int CMD_START = 0;
	localparam int CMD_STOP = 1;
	localparam int CMD_WRITE = 2;
	localparam int CMD_READ = 3;
	localparam int CMD_ACKV = 4;
	localparam int HI_DONE = 0;
	localparam int HI_NACK = 1;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_NS = 5;
	localparam int QUARTER_NS = 50;
	localparam int QUARTER_CYC = (QUARTER_NS + CLK_NS - 1) / CLK_NS;

	// ****************************************
	// state types
	// ****************************************
	typedef enum logic [2:0] {D_IDLE, D_ADDR, D_ADDR2, D_RX, D_TX, D_SKIP} i2csr_dst_t;
	typedef enum logic [1:0] {H_IDLE, H_START, H_STOP, H_BIT} i2csr_hst_t;

endpackage

// ===== core/i2csr_link_if.sv
// open-drain two-wire link joining the bus master and the slave port
`timescale 1ns/1ps
`default_nettype none

interface i2csr_link_if;
	logic scl_h_o;
	logic scl_h_oe;
	logic sda_h_o;
	logic sda_h_oe;
	logic scl_d_o;
	logic scl_d_oe;
	logic sda_d_o;
	logic sda_d_oe;
	logic scl;
	logic sda;

	// pulled high unless some end drives low
	assign scl = ~((scl_h_oe & ~scl_h_o) | (scl_d_oe & ~scl_d_o));
	assign sda = ~((sda_h_oe & ~sda_h_o) | (sda_d_oe & ~sda_d_o));

	modport host (output scl_h_o, scl_h_oe, sda_h_o, sda_h_oe, input scl, sda);
	modport dev (output scl_d_o, scl_d_oe, sda_d_o, sda_d_oe, input scl, sda);
endinterface

`default_nettype wire

// ===== core/i2csr_sync.sv
// two-flop synchroniser for the link pins
`timescale 1ns/1ps
`default_nettype none

module i2csr_sync #(
	parameter int W = 2
) (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	// pins
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);
	logic [W-1:0] meta_reg;

	// idle bus level is high
	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
		begin
			meta_reg <= '1;
			o_q <= '1;
		end
		else
		begin
			meta_reg <= i_d;
			o_q <= meta_reg;
		end
	end
endmodule

`default_nettype wire

// ===== core/i2csr_dev.sv
// two-wire slave port: addressing, receive, transmit and flags
`timescale 1ns/1ps
`default_nettype none

module i2csr_dev (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	// link
	i2csr_link_if.dev link,
	// configuration
	input wire logic i_enable,
	input wire logic i_ten_bit,
	input wire logic i_own_wr,
	input wire logic [i2csr_pkg::BYTE_W-1:0] i_own_addr,
	// data
	input wire logic i_buf_rd,
	output logic [i2csr_pkg::BYTE_W-1:0] o_rx_buf,
	input wire logic [i2csr_pkg::BYTE_W-1:0] i_tx_data,
	// flags and interrupt
	input wire logic [i2csr_pkg::INT_W-1:0] i_flag_clr,
	input wire logic [i2csr_pkg::INT_W-1:0] i_int_mask,
	output logic o_bf,
	output logic o_ov,
	output logic o_pif,
	output logic o_ua,
	output logic o_rw,
	output logic o_irq
);
	import i2csr_pkg::*;

	// ****************************************
	// pin sampling and edge detect
	// ****************************************
	logic [1:0] pin_s;
	logic scl_s, sda_s, scl_q, sda_q;
	logic scl_rise, scl_fall, start_c, stop_c;

	i2csr_sync #(.W(2)) u_sync (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_d({link.scl, link.sda}),
		.o_q(pin_s)
	);

	assign scl_s = pin_s[1];
	assign sda_s = pin_s[0];

	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
		begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end
		else
		begin
			scl_q <= scl_s;
			sda_q <= sda_s;
		end
	end

	assign scl_rise = scl_s & ~scl_q;
	assign scl_fall = ~scl_s & scl_q;
	assign start_c = scl_s & scl_q & sda_q & ~sda_s;
	assign stop_c = scl_s & scl_q & ~sda_q & sda_s;

	// ****************************************
	// byte sequencing
	// ****************************************
	i2csr_dst_t st_reg, nst_reg, nxt;
	logic [CNT_W-1:0] cnt_reg;
	logic [BYTE_W-1:0] sr_reg, own_reg, tsr_reg;
	logic bf_reg, ov_reg, pif_reg, ua_reg, rw_reg;
	logic ten_seen_reg, ack_reg, pend_reg, hold_reg, tx_drv_reg, mack_n_reg;
	logic hit, byte_end, tx_end, ninth_end, load, ua_set, tx_go;

	// address match on the completed byte
	always_comb
	begin
		hit = 1'b0;
		nxt = D_SKIP;
		case (st_reg)
			D_ADDR:
			begin
				if (sr_reg[7:1] == own_reg[7:1] && (!i_ten_bit || sr_reg[7:3] == TEN_HDR))
				begin
					if (!i_ten_bit)
					begin
						hit = 1'b1;
						nxt = sr_reg[0] ? D_TX : D_RX;
					end
					else if (!sr_reg[0])
					begin
						hit = 1'b1;
						nxt = D_ADDR2;
					end
					else if (ten_seen_reg)
					begin
						hit = 1'b1;
						nxt = D_TX;
					end
				end
			end
			D_ADDR2:
			begin
				if (sr_reg == own_reg)
				begin
					hit = 1'b1;
					nxt = D_RX;
				end
			end
			D_RX:
			begin
				hit = 1'b1;
				nxt = D_RX;
			end
			default:
			begin
				hit = 1'b0;
				nxt = D_SKIP;
			end
		endcase
	end

	assign byte_end = scl_fall && cnt_reg == BITS_PER_BYTE &&
		(st_reg == D_ADDR || st_reg == D_ADDR2 || st_reg == D_RX);
	assign tx_end = scl_fall && cnt_reg == BITS_PER_BYTE && st_reg == D_TX;
	assign ninth_end = scl_fall && cnt_reg == ACK_SLOT;
	assign load = byte_end & hit & ~bf_reg;
	assign ua_set = byte_end & hit & i_ten_bit &
		((st_reg == D_ADDR && !sr_reg[0]) || st_reg == D_ADDR2);
	assign tx_go = ninth_end && ((st_reg == D_TX && !mack_n_reg) ||
		(st_reg != D_TX && st_reg != D_SKIP && nst_reg == D_TX));

	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
		begin
			st_reg <= D_IDLE;
			nst_reg <= D_IDLE;
			cnt_reg <= '0;
			sr_reg <= '0;
		end
		else if (!i_enable)
		begin
			st_reg <= D_IDLE;
			cnt_reg <= '0;
		end
		else if (start_c)
		begin
			st_reg <= D_ADDR;
			cnt_reg <= '0;
		end
		else if (stop_c)
		begin
			st_reg <= D_IDLE;
			cnt_reg <= '0;
		end
		else
		begin
			if (scl_rise && st_reg != D_IDLE)
			begin
				cnt_reg <= cnt_reg + 4'h1;
				if (cnt_reg < BITS_PER_BYTE && st_reg != D_TX)
					sr_reg <= {sr_reg[6:0], sda_s};
			end
			if (byte_end)
				nst_reg <= hit ? nxt : D_SKIP;
			if (ninth_end)
			begin
				cnt_reg <= '0;
				if (st_reg == D_TX)
					st_reg <= mack_n_reg ? D_SKIP : D_TX;
				else if (st_reg != D_SKIP)
					st_reg <= nst_reg;
			end
		end
	end

	// ****************************************
	// acknowledge and transmit drive
	// ****************************************
	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
			ack_reg <= 1'b0;
		else if (start_c || stop_c || ninth_end || !i_enable)
			ack_reg <= 1'b0;
		else if (byte_end && hit && !bf_reg && !ov_reg)
			ack_reg <= 1'b1;
	end

	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
		begin
			tsr_reg <= '0;
			tx_drv_reg <= 1'b0;
			mack_n_reg <= 1'b0;
		end
		else if (start_c || stop_c || !i_enable)
			tx_drv_reg <= 1'b0;
		else if (tx_go)
		begin
			tsr_reg <= i_tx_data;
			tx_drv_reg <= 1'b1;
		end
		else if (st_reg == D_TX)
		begin
			if (scl_fall && cnt_reg == BITS_PER_BYTE)
				tx_drv_reg <= 1'b0;
			else if (scl_fall && cnt_reg != '0 && cnt_reg < BITS_PER_BYTE)
				tsr_reg <= {tsr_reg[6:0], 1'b0};
			if (scl_rise && cnt_reg == BITS_PER_BYTE)
				mack_n_reg <= sda_s;
		end
	end

	assign link.sda_d_o = 1'b0;
	assign link.sda_d_oe = ack_reg | (tx_drv_reg & ~tsr_reg[7]);
	assign link.scl_d_o = 1'b0;
	assign link.scl_d_oe = hold_reg;

	// ****************************************
	// buffer and flags
	// ****************************************
	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
			o_rx_buf <= '0;
		else if (load)
			o_rx_buf <= sr_reg;
	end

	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
			bf_reg <= 1'b0;
		else if (load)
			bf_reg <= 1'b1;
		else if (i_buf_rd)
			bf_reg <= 1'b0;
	end

	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
			ov_reg <= 1'b0;
		else if (byte_end && hit && bf_reg)
			ov_reg <= 1'b1;
		else if (i_flag_clr[INT_OV])
			ov_reg <= 1'b0;
	end

	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
			pend_reg <= 1'b0;
		else if ((byte_end && hit) || tx_end)
			pend_reg <= 1'b1;
		else if (ninth_end || start_c || stop_c)
			pend_reg <= 1'b0;
	end

	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
			pif_reg <= 1'b0;
		else if (ninth_end && pend_reg)
			pif_reg <= 1'b1;
		else if (i_flag_clr[INT_PIF])
			pif_reg <= 1'b0;
	end

	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
			ua_reg <= 1'b0;
		else if (ua_set)
			ua_reg <= 1'b1;
		else if (i_own_wr)
			ua_reg <= 1'b0;
	end

	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
			hold_reg <= 1'b0;
		else if (!ua_reg || !i_enable)
			hold_reg <= 1'b0;
		else if (ninth_end)
			hold_reg <= 1'b1;
	end

	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
			own_reg <= '0;
		else if (i_own_wr)
			own_reg <= i_own_addr;
	end

	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
			rw_reg <= 1'b0;
		else if (byte_end && hit && st_reg == D_ADDR)
			rw_reg <= sr_reg[0];
	end

	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
			ten_seen_reg <= 1'b0;
		else if (stop_c || !i_enable)
			ten_seen_reg <= 1'b0;
		else if (byte_end && hit && st_reg == D_ADDR2)
			ten_seen_reg <= 1'b1;
	end

	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
			o_irq <= 1'b0;
		else
			o_irq <= |({ov_reg, pif_reg} & i_int_mask);
	end

	assign o_bf = bf_reg;
	assign o_ov = ov_reg;
	assign o_pif = pif_reg;
	assign o_ua = ua_reg;
	assign o_rw = rw_reg;
endmodule

`default_nettype wire

// ===== core/i2csr_host.sv
// two-wire bus master with apb command registers
`timescale 1ns/1ps
`default_nettype none

module i2csr_host #(
	parameter int QCYC = i2csr_pkg::QUARTER_CYC
) (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	// apb slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [i2csr_pkg::AW-1:0] i_paddr,
	input wire logic [i2csr_pkg::DW-1:0] i_pwdata,
	output logic [i2csr_pkg::DW-1:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	output logic o_irq,
	// link
	i2csr_link_if.host link
);
	import i2csr_pkg::*;

	// ****************************************
	// pins
	// ****************************************
	logic [1:0] pin_s;
	logic scl_s, sda_s;

	i2csr_sync #(.W(2)) u_sync (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_d({link.scl, link.sda}),
		.o_q(pin_s)
	);

	assign scl_s = pin_s[1];
	assign sda_s = pin_s[0];

	// ****************************************
	// register access
	// ****************************************
	i2csr_hst_t st_reg;
	logic wr, mapped, cmd_go, done;
	logic [BYTE_W-1:0] txd_reg, rx_reg;
	logic [INT_W-1:0] ist_reg, imask_reg;
	logic ackrx_reg, rd_reg, ackv_reg;

	assign mapped = i_paddr == OFF_CTRL || i_paddr == OFF_TXD || i_paddr == OFF_RXD ||
		i_paddr == OFF_STAT || i_paddr == OFF_ISTAT || i_paddr == OFF_IMASK;
	assign wr = i_psel & i_penable & i_pwrite & mapped;
	assign cmd_go = wr && i_paddr == OFF_CTRL && st_reg == H_IDLE;
	assign o_pready = i_psel & i_penable;
	assign o_pslverr = i_psel & i_penable & ~mapped;

	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
			o_prdata <= '0;
		else if (i_psel && !i_penable)
		begin
			case (i_paddr)
				OFF_TXD: o_prdata <= {24'h000000, txd_reg};
				OFF_RXD: o_prdata <= {24'h000000, rx_reg};
				OFF_STAT: o_prdata <= {28'h0000000, sda_s, scl_s, ackrx_reg, st_reg != H_IDLE};
				OFF_ISTAT: o_prdata <= {30'h00000000, ist_reg};
				OFF_IMASK: o_prdata <= {30'h00000000, imask_reg};
				default: o_prdata <= '0;
			endcase
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
		begin
			txd_reg <= '0;
			imask_reg <= '0;
		end
		else if (wr)
		begin
			if (i_paddr == OFF_TXD)
				txd_reg <= i_pwdata[BYTE_W-1:0];
			if (i_paddr == OFF_IMASK)
				imask_reg <= i_pwdata[INT_W-1:0];
		end
	end

	// events win over a write-one clear
	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
			ist_reg <= '0;
		else
		begin
			for (int k = 0; k < INT_W; k++)
			begin
				// nack only after a written byte, not a stale bit at start or stop
				if ((k == HI_DONE && done) ||
					(k == HI_NACK && done && st_reg == H_BIT && !rd_reg && ackrx_reg))
					ist_reg[k] <= 1'b1;
				else if (wr && i_paddr == OFF_ISTAT && i_pwdata[k])
					ist_reg[k] <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
			o_irq <= 1'b0;
		else
			o_irq <= |(ist_reg & imask_reg);
	end

	// ****************************************
	// bit engine, four ticks per clock period
	// ****************************************
	logic [15:0] div_reg;
	logic tick;
	logic [1:0] ph_reg;
	logic [CNT_W-1:0] bit_reg;
	logic [BYTE_W-1:0] tsr_reg;
	logic scl_oe_reg, sda_oe_reg;

	assign tick = st_reg != H_IDLE && div_reg == 16'(QCYC - 1);
	assign done = tick && ph_reg == 2'h3 && (st_reg != H_BIT || bit_reg == BITS_PER_BYTE);

	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
			div_reg <= '0;
		else if (st_reg == H_IDLE || tick)
			div_reg <= '0;
		else
			div_reg <= div_reg + 16'h0001;
	end

	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
		begin
			st_reg <= H_IDLE;
			ph_reg <= '0;
			bit_reg <= '0;
			tsr_reg <= '0;
			rx_reg <= '0;
			rd_reg <= 1'b0;
			ackv_reg <= 1'b0;
			ackrx_reg <= 1'b0;
			scl_oe_reg <= 1'b0;
			sda_oe_reg <= 1'b0;
		end
		else if (cmd_go)
		begin
			ph_reg <= '0;
			bit_reg <= '0;
			tsr_reg <= txd_reg;
			rd_reg <= i_pwdata[CMD_READ] & ~i_pwdata[CMD_WRITE];
			ackv_reg <= i_pwdata[CMD_ACKV];
			if (i_pwdata[CMD_START])
				st_reg <= H_START;
			else if (i_pwdata[CMD_WRITE] || i_pwdata[CMD_READ])
				st_reg <= H_BIT;
			else if (i_pwdata[CMD_STOP])
				st_reg <= H_STOP;
		end
		else if (tick && !(ph_reg == 2'h2 && !scl_s))
		begin
			// phase 2 waits while a slave stretches the clock
			ph_reg <= ph_reg + 2'h1;
			case (ph_reg)
				2'h0:
				begin
					if (st_reg == H_START)
						sda_oe_reg <= 1'b0;
					else if (st_reg == H_STOP)
						sda_oe_reg <= 1'b1;
					else if (bit_reg < BITS_PER_BYTE)
						sda_oe_reg <= ~rd_reg & ~tsr_reg[7];
					else
						sda_oe_reg <= rd_reg & ~ackv_reg;
				end
				2'h1: scl_oe_reg <= 1'b0;
				2'h2:
				begin
					if (st_reg == H_START)
						sda_oe_reg <= 1'b1;
					else if (st_reg == H_BIT && bit_reg < BITS_PER_BYTE)
						rx_reg <= {rx_reg[6:0], sda_s};
					else if (st_reg == H_BIT)
						ackrx_reg <= sda_s;
				end
				default:
				begin
					if (st_reg == H_STOP)
						sda_oe_reg <= 1'b0;
					else
						scl_oe_reg <= 1'b1;
					tsr_reg <= {tsr_reg[6:0], 1'b0};
					bit_reg <= bit_reg + 4'h1;
					if (done)
						st_reg <= H_IDLE;
				end
			endcase
		end
	end

	assign link.scl_h_o = 1'b0;
	assign link.scl_h_oe = scl_oe_reg;
	assign link.sda_h_o = 1'b0;
	assign link.sda_h_oe = sda_oe_reg;
endmodule

`default_nettype wire

// ===== tb/i2csr_props.sv
// concurrent checks on the link and the slave port flags
`timescale 1ns/1ps
`default_nettype none

module i2csr_props (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	// link
	input wire logic scl,
	input wire logic scl_d_o,
	input wire logic scl_d_oe,
	input wire logic sda_d_o,
	input wire logic sda_d_oe,
	// slave port
	input wire logic i_own_wr,
	input wire logic i_buf_rd,
	input wire logic [i2csr_pkg::INT_W-1:0] i_flag_clr,
	input wire logic [i2csr_pkg::INT_W-1:0] i_int_mask,
	input wire logic [i2csr_pkg::BYTE_W-1:0] o_rx_buf,
	input wire logic o_bf,
	input wire logic o_ov,
	input wire logic o_pif,
	input wire logic o_ua,
	input wire logic o_irq
);
	import i2csr_pkg::*;

	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_rst);

	// ****************************************
	// checks
	// ****************************************
	chk_open_drain: assert property (!scl_d_o && !sda_d_o)
		else $error("slave drives a line high");
	chk_ack_load: assert property ($rose(o_bf) && !o_ov |-> ##[0:4] sda_d_oe)
		else $error("no ack with buffer load");
	chk_nack_ovf: assert property ($rose(o_ov) |-> !sda_d_oe [*4])
		else $error("ack given on overflow");
	chk_nack_stale: assert property (o_ov && $rose(o_bf) |-> !sda_d_oe [*4])
		else $error("ack given with overflow pending");
	chk_no_copy: assert property (o_bf && $past(o_bf) |-> $stable(o_rx_buf))
		else $error("buffer changed while full");
	chk_pif_late: assert property ($rose(o_pif) |-> !scl)
		else $error("interrupt flag not at clock fall");
	chk_rd_clear: assert property (i_buf_rd && scl |=> !o_bf)
		else $error("buffer read left full flag");
	chk_ov_sticky: assert property (o_ov && !i_flag_clr[INT_OV] |=> o_ov)
		else $error("overflow cleared without write");
	chk_irq_pif: assert property ((o_pif && i_int_mask[INT_PIF]) [*2] |-> o_irq)
		else $error("interrupt missing");
	chk_ua_hold: assert property (o_ua && scl_d_oe && !i_own_wr |=> scl_d_oe)
		else $error("clock released before address update");
endmodule

`default_nettype wire

// ===== tb/tb_i2c_slave_receiver.sv
// bench joining the bus master and the slave port over the link
`timescale 1ns/1ps
`default_nettype none

module tb_i2c_slave_receiver;
	import i2csr_pkg::*;
	logic i_mclk = 1'b0;
	logic i_rst = 1'b1;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [AW-1:0] pa = '0;
	logic [DW-1:0] pwd = '0;
	logic [DW-1:0] prd;
	logic [DW-1:0] q;
	logic prdy;
	logic perr;
	logic lerr;
	logic hirq;
	logic en = 1'b0;
	logic ten = 1'b0;
	logic own_wr = 1'b0;
	logic [7:0] own = 8'h00;
	logic buf_rd = 1'b0;
	logic [7:0] rxb;
	logic [7:0] txd = 8'hc5;
	logic [1:0] fclr = 2'b00;
	logic [1:0] mask = 2'b01;
	logic bf, ov, pif, ua, rw, dirq;
	logic [4:0] fl;
	int num_errors = 0;
	int total_checks = 0;

	assign fl = {bf, ov, pif, ua, rw};
	always #2.5 i_mclk = ~i_mclk;

	i2csr_link_if lk();
	i2csr_host #(.QCYC(4)) i_i2csr_host (.i_mclk(i_mclk), .i_rst(i_rst), .i_psel(psel),
		.i_penable(pen), .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd),
		.o_pready(prdy), .o_pslverr(perr), .o_irq(hirq), .link(lk.host));
	i2csr_dev i_i2csr_dev (.i_mclk(i_mclk), .i_rst(i_rst), .link(lk.dev), .i_enable(en),
		.i_ten_bit(ten), .i_own_wr(own_wr), .i_own_addr(own), .i_buf_rd(buf_rd),
		.o_rx_buf(rxb), .i_tx_data(txd), .i_flag_clr(fclr), .i_int_mask(mask), .o_bf(bf),
		.o_ov(ov), .o_pif(pif), .o_ua(ua), .o_rw(rw), .o_irq(dirq));
	i2csr_props i_i2csr_props (.i_mclk(i_mclk), .i_rst(i_rst), .scl(lk.scl),
		.scl_d_o(lk.scl_d_o), .scl_d_oe(lk.scl_d_oe), .sda_d_o(lk.sda_d_o),
		.sda_d_oe(lk.sda_d_oe), .i_own_wr(own_wr), .i_buf_rd(buf_rd), .i_flag_clr(fclr),
		.i_int_mask(mask), .o_rx_buf(rxb), .o_bf(bf), .o_ov(ov), .o_pif(pif), .o_ua(ua),
		.o_irq(dirq));

	task automatic report_and_stop;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d);
		@(posedge i_mclk);
		psel <= 1'b1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge i_mclk);
		pen <= 1'b1;
		do @(posedge i_mclk); while (prdy !== 1'b1);
		q = prd;
		lerr = perr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask

	// command, then poll busy until idle
	task automatic cmd(input logic [7:0] c);
		apb(1'b1, OFF_CTRL, {24'h000000, c});
		do apb(1'b0, OFF_STAT, '0); while (q[0] !== 1'b0);
		repeat (8) @(posedge i_mclk);
	endtask

	task automatic wbyte(input logic [7:0] b, input logic nk);
		apb(1'b1, OFF_TXD, {24'h000000, b});
		cmd(8'h04);
		apb(1'b0, OFF_STAT, '0);
		chk(q[1], nk);
	endtask

	// k: 0 own address write, 1 buffer read, 2 flag clear
	task automatic dpulse(input int k, input logic [7:0] v);
		@(posedge i_mclk);
		own_wr <= (k == 0);
		buf_rd <= (k == 1);
		fclr <= (k == 2) ? v[1:0] : 2'b00;
		if (k == 0)
			own <= v;
		@(posedge i_mclk);
		own_wr <= 1'b0;
		buf_rd <= 1'b0;
		fclr <= 2'b00;
		repeat (2) @(posedge i_mclk);
	endtask

	initial
	begin
		repeat (4) @(posedge i_mclk);
		i_rst <= 1'b0;
		en <= 1'b1;
		dpulse(0, 8'h84);
		apb(1'b1, OFF_IMASK, 32'h00000001);
		cmd(8'h01);
		wbyte(8'h84, 1'b0);
		chk(rxb, 8'h84);
		chk(fl, 5'b10100);
		chk(dirq, 1'b1);
		chk(hirq, 1'b1);
		apb(1'b1, OFF_ISTAT, 32'h00000003);
		apb(1'b0, 8'h1c, '0);
		chk(lerr, 1'b1);
		chk(q, 32'h00000000);
		chk(hirq, 1'b0);
		dpulse(1, 8'h00);
		dpulse(2, 8'h01);
		chk(fl, 5'b00000);
		chk(dirq, 1'b0);
		wbyte(8'h5a, 1'b0);
		chk(rxb, 8'h5a);
		wbyte(8'h33, 1'b1);
		chk(rxb, 8'h5a);
		chk(fl, 5'b11100);
		dpulse(2, 8'h01);
		chk(dirq, 1'b0);
		dpulse(1, 8'h00);
		chk(fl, 5'b01000);
		wbyte(8'h77, 1'b1);
		chk(rxb, 8'h77);
		dpulse(2, 8'h03);
		dpulse(1, 8'h00);
		cmd(8'h02);
		$display("test seven_bit done");
		cmd(8'h01);
		wbyte(8'h86, 1'b1);
		chk(fl, 5'b00000);
		// a stop after a refused byte must not raise the nack event again
		apb(1'b1, OFF_ISTAT, 32'h00000003);
		cmd(8'h02);
		apb(1'b0, OFF_ISTAT, '0);
		chk(q, 32'h00000001);
		$display("test mismatch done");
		ten <= 1'b1;
		dpulse(0, 8'hf2);
		cmd(8'h01);
		wbyte(8'hf2, 1'b0);
		chk(fl, 5'b10110);
		dpulse(0, 8'h34);
		chk(ua, 1'b0);
		dpulse(1, 8'h00);
		dpulse(2, 8'h01);
		wbyte(8'h34, 1'b0);
		chk(fl, 5'b10110);
		dpulse(0, 8'hf2);
		dpulse(1, 8'h00);
		dpulse(2, 8'h01);
		cmd(8'h01);
		wbyte(8'hf3, 1'b0);
		chk(fl, 5'b10101);
		dpulse(1, 8'h00);
		dpulse(2, 8'h01);
		cmd(8'h18);
		apb(1'b0, OFF_RXD, '0);
		chk(q[7:0], 8'hc5);
		cmd(8'h02);
		$display("test ten_bit done");
		report_and_stop;
	end

	initial
	begin
		repeat (40000) @(posedge i_mclk);
		num_errors++;
		$display("[ERR] %0t watchdog expired", $time);
		report_and_stop;
	end
endmodule

`default_nettype wire
